// ===== core/gpio_defs.svh
// register offsets, field positions, reset values and timing counts of the pin control block
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
`define ADDR_W 8
`define OFF_PIN_CTRL 8'hef
`define OFF_IRQ_STATUS 8'hf8
`define OFF_IRQ_MASK 8'hf9
`define RST_PIN_CTRL 16'h0000
`define RST_IRQ 2'h0
`define POS_TE_LEVEL 15
`define POS_TE_CTRL 8
`define POS_DBCL_LEVEL 7
`define POS_DBCL_CTRL 0
`define CTL_OWNER 0
`define CTL_DIR 1
`define CTL_OUT 2
`define CTL_PULL_LO 3
`define CTL_PULL_HI 4
`define CTL_IRQ_EN 5
`define CTL_IRQ_POL 6
`define PULL_NONE 2'h0
`define PULL_KEEPER 2'h1
`define PULL_UP 2'h2
`define SYNC_STAGES 3
`endif

// ===== core/gpio_pkg.sv
// types shared by the pin control block
package gpio_pkg;
  typedef struct packed {
    logic irq_pol;
    logic irq_en;
    logic [1:0] pull;
    logic out_level;
    logic dir_out;
    logic owner_reg;
  } pin_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pull_up;
    logic keeper;
    logic irq;
  } pin_drive_t;
endpackage : gpio_pkg

// ===== core/pin_sync.sv
// three-stage synchroniser for one pin input with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin in, clean level out
  input wire logic pin_in,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  wire agree = (s2_reg == s3_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level = level_reg;
endmodule : pin_sync
`default_nettype wire

// ===== core/pin_ctrl.sv
// per-pin owner, direction, pull and interrupt decode
`timescale 1ns/10ps
`default_nettype none
`include "gpio_defs.svh"
module pin_ctrl
  import gpio_pkg::*;
(
  // control field and pin state
  input wire pin_ctrl_t ctrl,
  input wire logic level,
  // module-side function
  input wire logic mod_o,
  input wire logic mod_oe,
  // resulting pin drive
  output pin_drive_t drive
);
  wire reg_mode = ctrl.owner_reg;
  wire reg_out = reg_mode & ctrl.dir_out;
  wire is_input = reg_mode ? ~ctrl.dir_out : ~mod_oe;
  wire active = ctrl.irq_pol ? level : ~level;

  assign drive.oe = reg_mode ? reg_out : mod_oe;
  assign drive.o = reg_mode ? ctrl.out_level : mod_o;
  // pull only acts on an input; 11 is treated as no pull
  assign drive.pull_up = is_input & (ctrl.pull == `PULL_UP);
  assign drive.keeper = is_input & (ctrl.pull == `PULL_KEEPER);
  assign drive.irq = reg_mode & ~ctrl.dir_out & ctrl.irq_en & active;
endmodule : pin_ctrl
`default_nettype wire

// ===== core/dual_pin_gpio.sv
// register and pin logic for the tearing-effect and data-bus clock pins
// Overview of operation
// - bit 15 reads the synchronised tearing-effect pin level while it is an input
// - bits 14:8 control the tearing-effect pin exactly like bits 6:0
// - bit 7 reads the synchronised data-bus clock pin level while it is an input
// - bits 6:0 control the data-bus clock pin
// - control bit 0: 0 module owns pin, 1 register owns pin
// - control bit 1 sets direction in register mode, 1 output
// - control bit 2 sets driven level in register mode
// - bits 4:3 pull: 00 none, 10 pull-up, 01 keeper, inputs only
// - bit 5 enables interrupt from the pin while it is an input in register mode
// - bit 6 selects interrupt polarity, 1 active high
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_defs.svh"
module dual_pin_gpio
  import gpio_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // register port
  input wire logic [`ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // module-side functions
  input wire logic TE_MOD_O,
  input wire logic TE_MOD_OE,
  input wire logic DBCL_MOD_O,
  input wire logic DBCL_MOD_OE,
  // tearing-effect pin
  input wire logic TE_I,
  output logic TE_O,
  output logic TE_OE,
  output logic TE_PULLUP,
  output logic TE_KEEPER,
  // data-bus clock pin
  input wire logic DBCL_I,
  output logic DBCL_O,
  output logic DBCL_OE,
  output logic DBCL_PULLUP,
  output logic DBCL_KEEPER,
  // levels toward the other functions and interrupt
  output logic TE_LEVEL,
  output logic DBCL_LEVEL,
  output logic PIN_IRQ,
  output logic IRQ
);
  pin_ctrl_t te_pin_control_reg;
  pin_ctrl_t dbcl_pin_control_reg;
  logic te_pin_level_reg;
  logic dbcl_pin_level_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [15:0] rdata_reg;
  pin_drive_t te_drv_reg;
  pin_drive_t dbcl_drv_reg;
  logic pin_irq_reg;
  logic irq_reg;
  logic te_sync;
  logic dbcl_sync;
  pin_drive_t te_drv;
  pin_drive_t dbcl_drv;

  pin_sync u_te_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in(TE_I),
    .level(te_sync)
  );

  pin_sync u_dbcl_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in(DBCL_I),
    .level(dbcl_sync)
  );

  pin_ctrl u_te_ctrl (
    .ctrl(te_pin_control_reg),
    .level(te_sync),
    .mod_o(TE_MOD_O),
    .mod_oe(TE_MOD_OE),
    .drive(te_drv)
  );

  pin_ctrl u_dbcl_ctrl (
    .ctrl(dbcl_pin_control_reg),
    .level(dbcl_sync),
    .mod_o(DBCL_MOD_O),
    .mod_oe(DBCL_MOD_OE),
    .drive(dbcl_drv)
  );

  // address decode
  wire sel_ctrl = (ADDR == `OFF_PIN_CTRL);
  wire sel_stat = (ADDR == `OFF_IRQ_STATUS);
  wire sel_mask = (ADDR == `OFF_IRQ_MASK);
  wire wr_ctrl = WR & sel_ctrl;
  wire wr_stat = WR & sel_stat;
  wire wr_mask = WR & sel_mask;

  // status holds its last value while the pin drives, reflecting only input state
  wire te_is_in = ~te_drv.oe;
  wire dbcl_is_in = ~dbcl_drv.oe;
  wire te_level_next = te_is_in ? te_sync : te_pin_level_reg;
  wire dbcl_level_next = dbcl_is_in ? dbcl_sync : dbcl_pin_level_reg;

  // rising edge of each pin's interrupt request sets a sticky bit; set beats clear
  wire [1:0] irq_src = {te_drv.irq, dbcl_drv.irq};
  wire [1:0] irq_prev = {te_drv_reg.irq, dbcl_drv_reg.irq};
  wire [1:0] irq_rise = irq_src & ~irq_prev;
  wire [1:0] clr_mask = wr_stat ? WDATA[1:0] : 2'h0;
  wire [1:0] irq_status_next = irq_rise | (irq_status_reg & ~clr_mask);
  wire [1:0] irq_mask_next = wr_mask ? WDATA[1:0] : irq_mask_reg;

  wire [15:0] ctrl_word = {te_pin_level_reg, te_pin_control_reg, dbcl_pin_level_reg, dbcl_pin_control_reg};
  // unmapped addresses read zero
  wire [15:0] rdata_next = !RD ? 16'h0000 :
                           sel_ctrl ? ctrl_word :
                           sel_stat ? {14'h0000, irq_status_reg} :
                           sel_mask ? {14'h0000, irq_mask_reg} : 16'h0000;

  // reset values of the two control fields, cut from the register's reset word
  localparam logic [15:0] RST_CTRL_WORD = `RST_PIN_CTRL;
  localparam pin_ctrl_t RST_TE_CTRL = pin_ctrl_t'(RST_CTRL_WORD[14:8]);
  localparam pin_ctrl_t RST_DBCL_CTRL = pin_ctrl_t'(RST_CTRL_WORD[6:0]);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      te_pin_control_reg <= RST_TE_CTRL;
    end else if (wr_ctrl) begin
      te_pin_control_reg <= pin_ctrl_t'(WDATA[14:8]);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dbcl_pin_control_reg <= RST_DBCL_CTRL;
    end else if (wr_ctrl) begin
      dbcl_pin_control_reg <= pin_ctrl_t'(WDATA[6:0]);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      te_pin_level_reg <= 1'b0;
    end else begin
      te_pin_level_reg <= te_level_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dbcl_pin_level_reg <= 1'b0;
    end else begin
      dbcl_pin_level_reg <= dbcl_level_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_status_reg <= `RST_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_mask_reg <= `RST_IRQ;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // pin drive is registered so every output leaves a flip-flop; costs one cycle of latency
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      te_drv_reg <= '0;
    end else begin
      te_drv_reg <= te_drv;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dbcl_drv_reg <= '0;
    end else begin
      dbcl_drv_reg <= dbcl_drv;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_irq_reg <= 1'b0;
    end else begin
      pin_irq_reg <= te_drv.irq | dbcl_drv.irq;
    end
  end

  // built from next values so the line follows status and mask without an extra cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_next);
    end
  end

  assign RDATA = rdata_reg;
  assign TE_O = te_drv_reg.o;
  assign TE_OE = te_drv_reg.oe;
  assign TE_PULLUP = te_drv_reg.pull_up;
  assign TE_KEEPER = te_drv_reg.keeper;
  assign DBCL_O = dbcl_drv_reg.o;
  assign DBCL_OE = dbcl_drv_reg.oe;
  assign DBCL_PULLUP = dbcl_drv_reg.pull_up;
  assign DBCL_KEEPER = dbcl_drv_reg.keeper;
  assign TE_LEVEL = te_pin_level_reg;
  assign DBCL_LEVEL = dbcl_pin_level_reg;
  assign PIN_IRQ = pin_irq_reg;
  assign IRQ = irq_reg;
endmodule : dual_pin_gpio
`default_nettype wire

// ===== tb/pin_partner.sv
// far side of one pin: driven from outside, else pulled, kept or floating
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  // clock
  input wire logic clk,
  // far-side drive
  input wire logic drv,
  input wire logic val,
  // block drive
  input wire logic o,
  input wire logic oe,
  input wire logic pu,
  input wire logic kp,
  // resolved pin
  output logic pin
);
  logic last = 1'b0;
  // a floating line toggles so a stale level is never taken for a real one
  always_ff @(posedge clk) last <= (pin === 1'b1);
  assign pin = oe ? o : drv ? val : pu ? 1'b1 : kp ? last : ~last;
endmodule : pin_partner
`default_nettype wire

// ===== tb/dual_pin_gpio_asserts.sv
// port checks of the pin control block
`timescale 1ns/10ps
`default_nettype none
`include "gpio_defs.svh"
module dual_pin_gpio_asserts (
  // clock, reset, register port
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [`ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // pins
  input wire logic DBCL_MOD_OE,
  input wire logic TE_O,
  input wire logic TE_OE,
  input wire logic DBCL_O,
  input wire logic DBCL_OE,
  input wire logic DBCL_PULLUP,
  input wire logic DBCL_KEEPER,
  input wire logic TE_LEVEL,
  input wire logic DBCL_LEVEL,
  input wire logic PIN_IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // status bits never take write data
  logic [15:0] sh_reg;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) sh_reg <= 16'h0000;
    else if (WR && ADDR == `OFF_PIN_CTRL) sh_reg <= WDATA & 16'h7f7f;
  end
  wire logic den = sh_reg[0] & ~sh_reg[1] & sh_reg[5];
  wire logic ten = sh_reg[8] & ~sh_reg[9] & sh_reg[13];
  sequence s_ctl_read;
    RD && ADDR == `OFF_PIN_CTRL;
  endsequence
  // the request and the status bit both come from the level one cycle back, under last cycle's field
  sequence s_dbcl_active;
    $past(den) && DBCL_LEVEL == $past(sh_reg[6]);
  endsequence
  a_rdata_idle:
    assert property (!RD |=> RDATA == 16'h0000) else $error("read data not idle");
  a_read_back:
    assert property (s_ctl_read |=> RDATA == {$past(TE_LEVEL), $past(sh_reg[14:8]), $past(DBCL_LEVEL),
      $past(sh_reg[6:0])}) else $error("control read wrong");
  a_module_drive:
    assert property (!sh_reg[0] |=> DBCL_OE == $past(DBCL_MOD_OE)) else $error("module drive lost");
  a_dbcl_drive:
    assert property (sh_reg[1:0] == 2'h3 |=> DBCL_OE && DBCL_O == $past(sh_reg[2])) else $error("dbcl drive wrong");
  a_te_drive:
    assert property (sh_reg[9:8] == 2'h3 |=> TE_OE && TE_O == $past(sh_reg[10])) else $error("te drive wrong");
  a_pull_up:
    assert property (sh_reg[4:0] == 5'h11 |=> DBCL_PULLUP && !DBCL_KEEPER) else $error("pull-up wrong");
  a_irq_active:
    assert property (s_dbcl_active |-> PIN_IRQ) else $error("pin interrupt missing");
  a_irq_quiet:
    assert property (!den && !ten |=> !PIN_IRQ) else $error("pin interrupt unexpected");
endmodule : dual_pin_gpio_asserts
bind dual_pin_gpio dual_pin_gpio_asserts u_dual_pin_gpio_asserts (.CLK_SYS, .SYS_RST, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .DBCL_MOD_OE, .TE_O, .TE_OE, .DBCL_O, .DBCL_OE, .DBCL_PULLUP, .DBCL_KEEPER, .TE_LEVEL, .DBCL_LEVEL,
  .PIN_IRQ);
`default_nettype wire

// ===== tb/dual_pin_gpio_control_bench.sv
// self-checking bench of the pin control block
`timescale 1ns/10ps
`default_nettype none
`include "gpio_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module dual_pin_gpio_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] mo = 2'h0, moe = 2'h0, xd = 2'h3, xv = 2'h0;
  wire [1:0] pin, o, oe, pu, kp, lvl;
  wire pirq, irq;
  wire [15:0] rdata;
  int failures = 0, checked = 0;
  always #5 clk = ~clk;
  dual_pin_gpio u_dual_pin_gpio (.CLK_SYS(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TE_MOD_O(mo[1]), .TE_MOD_OE(moe[1]), .DBCL_MOD_O(mo[0]), .DBCL_MOD_OE(moe[0]),
    .TE_I(pin[1]), .TE_O(o[1]), .TE_OE(oe[1]), .TE_PULLUP(pu[1]), .TE_KEEPER(kp[1]),
    .DBCL_I(pin[0]), .DBCL_O(o[0]), .DBCL_OE(oe[0]), .DBCL_PULLUP(pu[0]), .DBCL_KEEPER(kp[0]),
    .TE_LEVEL(lvl[1]), .DBCL_LEVEL(lvl[0]), .PIN_IRQ(pirq), .IRQ(irq));
  for (genvar i = 0; i < 2; i++) begin : g_pin
    pin_partner u_pin_partner (.clk(clk), .drv(xd[i]), .val(xv[i]), .o(o[i]), .oe(oe[i]), .pu(pu[i]), .kp(kp[i]),
      .pin(pin[i]));
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic t_reset();
    rd_chk(`OFF_PIN_CTRL, `RST_PIN_CTRL);
    rd_chk(8'h00, 16'h0000);
    `CHK("outputs", 12'h000, {o, oe, pu, kp, lvl, pirq, irq})
    $display("reset test done");
  endtask : t_reset
  task automatic t_fields();
    wr_reg(`OFF_PIN_CTRL, 16'hffff);
    settle(2);
    `CHK("drive", 4'hf, {oe, o})
    `CHK("pull irq", 5'h00, {pu, kp, pirq})
    rd_chk(`OFF_PIN_CTRL, 16'h7f7f);
    wr_reg(`OFF_PIN_CTRL, 16'h0000);
    // released pins fall back to the far-side low level only after the synchroniser
    settle(8);
    rd_chk(`OFF_PIN_CTRL, 16'h0000);
    $display("field test done");
  endtask : t_fields
  task automatic t_owner();
    wr_reg(`OFF_PIN_CTRL, 16'h0606);
    settle(2);
    `CHK("oe", 2'h0, oe)
    @(posedge clk);
    moe <= 2'h3;
    mo <= 2'h1;
    settle(2);
    `CHK("module drive", 4'hd, {oe, o})
    @(posedge clk);
    moe <= 2'h0;
    $display("owner test done");
  endtask : t_owner
  task automatic t_pull();
    logic [4:0] c;
    for (int p = 0; p < 4; p++) begin
      c = {p[1:0], 3'b001};
      wr_reg(`OFF_PIN_CTRL, {2{3'b000, c}});
      settle(2);
      `CHK("pull", {{2{p == 2}}, {2{p == 1}}}, {pu, kp})
    end
    $display("pull test done");
  endtask : t_pull
  task automatic t_level();
    wr_reg(`OFF_PIN_CTRL, 16'h0101);
    xv <= 2'h2;
    settle(8);
    `CHK("level pins", 2'h2, lvl)
    rd_chk(`OFF_PIN_CTRL, 16'h8101);
    @(posedge clk);
    xv <= 2'h1;
    settle(8);
    rd_chk(`OFF_PIN_CTRL, 16'h0181);
    // outputs low now, so the held status bits must keep the last input levels
    wr_reg(`OFF_PIN_CTRL, 16'h0303);
    settle(8);
    rd_chk(`OFF_PIN_CTRL, 16'h0383);
    $display("level test done");
  endtask : t_level
  task automatic t_irq(input int k, input logic pol);
    logic [15:0] c;
    c = {9'h000, pol, 6'h21} << (8 * k);
    @(posedge clk);
    xv[k] <= ~pol;
    wr_reg(`OFF_PIN_CTRL, c);
    settle(8);
    `CHK("idle irq", 1'b0, pirq)
    @(posedge clk);
    xv[k] <= pol;
    settle(8);
    `CHK("pin irq", 1'b1, pirq)
    rd_chk(`OFF_IRQ_STATUS, 16'h1 << k);
    `CHK("masked", 1'b0, irq)
    wr_reg(`OFF_IRQ_MASK, 16'h1 << k);
    settle(2);
    `CHK("unmasked", 1'b1, irq)
    wr_reg(`OFF_IRQ_STATUS, 16'h1 << k);
    settle(2);
    `CHK("cleared", 1'b0, irq)
    wr_reg(`OFF_IRQ_MASK, 16'h0000);
    wr_reg(`OFF_PIN_CTRL, c ^ (16'h1 << (8 * k)));
    settle(2);
    `CHK("owner off", 1'b0, pirq)
    $display("interrupt test done");
  endtask : t_irq
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_owner();
    t_pull();
    t_level();
    for (int k = 0; k < 2; k++) begin
      t_irq(k, 1'b0);
      t_irq(k, 1'b1);
    end
    summarize();
  end
  // far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule : dual_pin_gpio_control_bench
`default_nettype wire
